// ---- adc_seq_pkg.sv ----
// Constants for the serial read-out and channel sequencer of a four-channel converter.
// Assumes a single 40 MHz clock; the sequencer synchronises all control pins into that domain itself.
// Behaviour
// R1 - With select low and read/convert high, shift latest result out on link clock.
// R2 - Frame marker rises after first data clock rising edge, stays one clock period.
// R3 - MSB valid after second rising data clock edge, then one bit per clock.
// R4 - LSB valid at 13th falling and 14th rising data clock edge.
// R5 - Sample one daisy-chain bit on every data clock pulse.
// R6 - First chain bit appears at 14th falling and 15th rising edge, and onward.
// R7 - Keep forwarding chain bits until the next result reloads the output register.
// R8 - Previous result stays readable up to 12 us after conversion start.
// R9 - Host must not clock data from 12 us after start until busy rises.
// R10 - Host should avoid running the data clock during conversion.
// R11 - Internal-clock mode: chain bit at first clock follows the 12 result bits.
// R12 - Scan select high: convert continuously through four channels while controls low.
// R13 - Scan starts on the channel after the last latched address, increasing.
// R14 - Scan mode: address pins output; busy rise increments latch and drives address.
// R15 - Scan address shows channel acquired or converted; data is previous channel.
// R16 - Power-down pulse of 200 ns when idle resets address to zero on fall.
// R17 - Host should wait for reference recharge before enabling scan mode.
// R18 - Manual mode: conversion start latches address pins for the next conversion.
// R19 - Manual mode: latched channel acquired once busy goes high.
// R20 - Convert commands are ignored while busy is low.
// R21 - Manual start: read/convert falls with select low, or select falls with it low.
// R22 - Scan mode: convert command while busy high restarts on the next channel.
// R23 - Power-down makes conversion data meaningless and resets scan channel to zero.
// R24 - Data clock is input; serial output driven only with select low, read high.
// R25 - Serial result is 12 bits, most significant bit first.
// R26 - With select tied low host keeps read or clock low during load window.
// R27 - Synchronise the data clock and represent conversion time as a cycle count.
// R28 - Busy falls at each accepted start and rises after the result is loaded.
package adc_seq_pkg;
    localparam int          CLK_HZ          = 40_000_000;
    localparam int          RESULT_BITS     = 12;
    localparam int          CONV_TIME_NS    = 15_000;
    localparam int          PREV_VALID_NS   = 12_000;
    localparam int          PD_MIN_NS       = 200;
    localparam int          CONV_CYCLES     = (CONV_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int          PREV_CYCLES     = (PREV_VALID_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int          PD_MIN_CYCLES   = (PD_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int          INT_DIV         = 22;
    localparam logic [1:0]  CHAN_LAST       = 2'h3;
    localparam logic [1:0]  CHAN_FIRST      = 2'h0;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_RUN  = 2'b01,
        CONV_LOAD = 2'b10
    } conv_state_t;
endpackage : adc_seq_pkg

// ---- adc_result_fifo.sv ----
// Small flip-flop FIFO carrying conversion results to the serial output register.
// Assumes both sides sit on mclk.
`timescale 1ns/1ps
module adc_result_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_reg[rd_ptr_reg];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule : adc_result_fifo

// ---- adc_serial_sequencer.sv ----
// Digital control of a four-channel converter: conversion start, channel sequencing
// and serial read-out under an external or internal data clock.
// Assumes all control pins are asynchronous to mclk; the analog core supplies a result word.
`timescale 1ns/1ps
module adc_serial_sequencer
    import adc_seq_pkg::*;
#(
    parameter int CONV_CYC  = CONV_CYCLES,
    parameter int PREV_CYC  = PREV_CYCLES,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic                   cs_n,
    input  wire logic                   read_conv,
    input  wire logic                   analog_powerdown,
    input  wire logic                   auto_scan_select,
    input  wire logic                   clock_source_select,
    input  wire logic                   serial_shift_clock_in,
    output logic                        serial_shift_clock_out,
    output logic                        serial_shift_clock_oe,
    input  wire logic                   chain_in,
    input  wire logic                   chan_addr_bit0_in,
    input  wire logic                   chan_addr_bit1_in,
    output logic                        chan_addr_bit0_out,
    output logic                        chan_addr_bit1_out,
    output logic                        chan_addr_oe,
    input  wire logic [RESULT_BITS-1:0] core_result,
    output logic      [1:0]             core_channel,
    output logic                        core_sample,
    output logic                        busy_n,
    output logic                        frame_marker,
    output logic                        serial_result_out,
    output logic                        serial_result_oe,
    output logic                        result_invalid,
    output logic                        result_overflow
);
    // ==================================================================
    // Input synchronisers
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    logic [NSYNC-1:0] raw_in;
    logic             cs_s, rc_s, pd_s, scan_s, ext_s, dclk_s, chain_s;
    logic [1:0]       addr_in_s;
    logic [1:0]       addr_in_reg;

    assign raw_in = {cs_n, read_conv, analog_powerdown, auto_scan_select,
                     clock_source_select, serial_shift_clock_in, chain_in};

    always_ff @(posedge mclk or negedge reset_n) begin // R27
        if (!reset_n) begin
            // Select resets to its idle high level, so no false fall follows reset
            sync1_reg <= 7'h40;
            sync2_reg <= 7'h40;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Address pins are sampled every cycle; only manual mode uses the sampled value
    logic [1:0] addr_s1_reg;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            addr_s1_reg <= '0;
            addr_in_reg <= '0;
        end else begin
            addr_s1_reg <= {chan_addr_bit1_in, chan_addr_bit0_in};
            addr_in_reg <= addr_s1_reg;
        end
    end
    assign addr_in_s = addr_in_reg;

    assign {cs_s, rc_s, pd_s, scan_s, ext_s, dclk_s, chain_s} = sync2_reg;

    // ==================================================================
    // Edge detection on synchronised levels
    logic cs_d_reg, rc_d_reg, pd_d_reg, dclk_d_reg, scan_d_reg;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cs_d_reg   <= 1'b1;
            rc_d_reg   <= 1'b0;
            pd_d_reg   <= 1'b0;
            dclk_d_reg <= 1'b0;
            scan_d_reg <= 1'b0;
        end else begin
            cs_d_reg   <= cs_s;
            rc_d_reg   <= rc_s;
            pd_d_reg   <= pd_s;
            dclk_d_reg <= dclk_s;
            scan_d_reg <= scan_s;
        end
    end

    logic cs_fall, rc_fall, pd_fall, dclk_rise, dclk_fall, scan_rise;
    assign cs_fall   = cs_d_reg && !cs_s;
    assign rc_fall   = rc_d_reg && !rc_s;
    assign pd_fall   = pd_d_reg && !pd_s;
    assign dclk_rise = !dclk_d_reg && dclk_s;
    assign dclk_fall = dclk_d_reg && !dclk_s;
    assign scan_rise = !scan_d_reg && scan_s;

    // ==================================================================
    // Conversion control
    conv_state_t state_reg;
    logic [15:0] conv_cnt_reg;
    logic [4:0]  pd_cnt_reg;
    logic [1:0]  chan_latch_reg;
    logic [1:0]  conv_chan_reg;
    logic        pd_seen_reg;
    logic        cmd_start, scan_start, start;
    logic        busy;
    logic        load_pulse;
    logic        fifo_in_ready;

    assign busy = (state_reg != CONV_IDLE);
    assign cmd_start  = (rc_fall && !cs_s) || (cs_fall && !rc_s); // R21
    // Scan mode runs back to back while all controls sit low
    assign scan_start = scan_s && !cs_s && !rc_s && !pd_s; // R12
    // Scan entry first steps the latch; the start waits one cycle for it
    assign start = !busy && !pd_s && !scan_rise && (scan_s ? (scan_start || cmd_start) : cmd_start); // R20

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg    <= CONV_IDLE;
            conv_cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                CONV_IDLE: begin
                    if (start) begin
                        state_reg    <= CONV_RUN; // R28
                        conv_cnt_reg <= '0;
                    end
                end
                CONV_RUN: begin
                    conv_cnt_reg <= conv_cnt_reg + 1'b1;
                    if (conv_cnt_reg == 16'(CONV_CYC - 1)) begin
                        state_reg <= CONV_LOAD;
                    end
                end
                CONV_LOAD: begin
                    // Busy only rises once the word has been accepted
                    if (fifo_in_ready) begin
                        state_reg <= CONV_IDLE; // R28
                    end
                end
                default: state_reg <= CONV_IDLE;
            endcase
        end
    end
    assign load_pulse = (state_reg == CONV_LOAD) && fifo_in_ready;
    assign busy_n     = !busy;
    assign core_sample = start;
    assign core_channel = conv_chan_reg;

    // Power-down pulse width measured while no conversion runs
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pd_cnt_reg  <= '0;
            pd_seen_reg <= 1'b0;
        end else if (pd_s && !busy) begin
            if (pd_cnt_reg != 5'(PD_MIN_CYCLES)) begin
                pd_cnt_reg <= pd_cnt_reg + 1'b1;
            end
            pd_seen_reg <= (pd_cnt_reg + 1'b1 >= 5'(PD_MIN_CYCLES)) || pd_seen_reg;
        end else if (!pd_s) begin
            pd_cnt_reg  <= '0;
            pd_seen_reg <= 1'b0;
        end
    end

    // Channel latch: holds the channel of the next conversion
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            chan_latch_reg <= CHAN_FIRST;
            conv_chan_reg  <= CHAN_FIRST;
        end else begin
            if (pd_fall && pd_seen_reg) begin
                chan_latch_reg <= CHAN_FIRST; // R16
            end else if (scan_s && pd_s) begin
                chan_latch_reg <= CHAN_FIRST; // R23
            end else if (scan_rise) begin
                chan_latch_reg <= chan_latch_reg + 1'b1; // R13
            end else if (!scan_s && start) begin
                conv_chan_reg  <= chan_latch_reg; // R19
                chan_latch_reg <= addr_in_s; // R18
            end else if (scan_s && start) begin // R22
                conv_chan_reg <= chan_latch_reg;
            end else if (scan_s && load_pulse) begin
                // Wraps to zero after the last channel
                chan_latch_reg <= (chan_latch_reg == CHAN_LAST) ? CHAN_FIRST : chan_latch_reg + 1'b1; // R14 R16
            end
        end
    end

    assign chan_addr_oe       = scan_s; // R14
    assign chan_addr_bit0_out = chan_latch_reg[0]; // R15
    assign chan_addr_bit1_out = chan_latch_reg[1]; // R15

    // ==================================================================
    // Result path: meaningless data flag travels with each word
    logic                   pd_during_reg;
    logic [RESULT_BITS+1:0] fifo_out_data;
    logic                   fifo_out_valid;
    logic                   fifo_out_ready;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pd_during_reg <= 1'b0;
        end else if (start) begin
            pd_during_reg <= 1'b0;
        end else if (busy && pd_s) begin
            pd_during_reg <= 1'b1; // R23
        end
    end

    adc_result_fifo #(
        .WIDTH (RESULT_BITS + 2),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .in_valid  (state_reg == CONV_LOAD),
        .in_ready  (fifo_in_ready),
        .in_data   ({pd_during_reg, conv_chan_reg[0], core_result}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // ==================================================================
    // Serial output register
    logic [RESULT_BITS-1:0] shift_reg;
    logic [4:0]             edge_cnt_reg;
    logic                   frame_reg;
    logic                   sout_reg;
    logic                   invalid_reg;
    logic                   chain_cap_reg;
    logic                   int_mode;
    logic [4:0]             div_cnt_reg;
    logic                   int_clk_reg;
    logic                   int_tick;
    logic                   read_en;
    logic                   overflow_reg;

    assign int_mode = !ext_s;
    assign read_en  = !cs_s && rc_s;
    // The output register reloads unless a read window is open with the data clock high;
    // in internal mode it reloads when a new conversion starts
    assign fifo_out_ready = fifo_out_valid && (int_mode ? start : !(read_en && dclk_s));

    // Internal data clock: divided enable pulse, at most 24 pulses per conversion
    assign int_tick = int_mode && busy && (div_cnt_reg == 5'(INT_DIV - 1))
                      && (edge_cnt_reg != 5'(2 * RESULT_BITS));
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt_reg <= '0;
            int_clk_reg <= 1'b0;
        end else if (!busy || !int_mode) begin
            div_cnt_reg <= '0;
            int_clk_reg <= 1'b0;
        end else begin
            div_cnt_reg <= (div_cnt_reg == 5'(INT_DIV - 1)) ? '0 : div_cnt_reg + 1'b1;
            if (int_tick) begin
                int_clk_reg <= !int_clk_reg;
            end
        end
    end

    logic srise, sfall;
    assign srise = int_mode ? (int_tick && !int_clk_reg) : (read_en && dclk_rise);
    assign sfall = int_mode ? (int_tick && int_clk_reg) : (read_en && dclk_fall);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            shift_reg     <= '0;
            edge_cnt_reg  <= '0;
            frame_reg     <= 1'b0;
            sout_reg      <= 1'b0;
            invalid_reg   <= 1'b0;
            chain_cap_reg <= 1'b0;
            overflow_reg  <= 1'b0;
        end else begin
            if (fifo_out_ready) begin
                // Reload discards any forwarded chain bits
                shift_reg    <= fifo_out_data[RESULT_BITS-1:0]; // R7 R8
                invalid_reg  <= fifo_out_data[RESULT_BITS+1];
                edge_cnt_reg <= '0;
                sout_reg     <= 1'b0;
            end else if (!int_mode && !read_en) begin
                edge_cnt_reg <= '0;
            end else if (srise) begin
                // Saturates so a long continuous clock never fakes a new first edge
                if (edge_cnt_reg != '1) begin
                    edge_cnt_reg <= edge_cnt_reg + 1'b1;
                end
                frame_reg <= (edge_cnt_reg == '0) && !int_mode; // R2
                if (edge_cnt_reg == '0 || !int_mode) begin
                    chain_cap_reg <= chain_s; // R5 R11
                end
                // External clock: MSB follows the second rise, chain bits trail one stage behind
                if (edge_cnt_reg != '0 || int_mode) begin
                    sout_reg  <= shift_reg[RESULT_BITS-1]; // R3 R4 R6 R25
                    shift_reg <= {shift_reg[RESULT_BITS-2:0], chain_cap_reg}; // R7
                end
            end else if (sfall && int_mode && edge_cnt_reg == 5'(RESULT_BITS)) begin
                sout_reg <= chain_cap_reg; // R11
            end
            // External clock: a word held back by a read with the data clock high raises overflow until the FIFO empties
            overflow_reg <= (fifo_out_valid && !fifo_out_ready && !int_mode) || overflow_reg && fifo_out_valid;
        end
    end

    assign frame_marker           = frame_reg;
    assign serial_result_out      = sout_reg; // R1
    assign serial_result_oe       = int_mode ? busy : read_en; // R24
    assign serial_shift_clock_out = int_clk_reg;
    assign serial_shift_clock_oe  = int_mode; // R24
    assign result_invalid         = invalid_reg;
    assign result_overflow        = overflow_reg;
endmodule : adc_serial_sequencer

// ---- adc_serial_sequencer_sva.sv ----
// Concurrent checks on the sequencer pins, bound into its top module.
// Assumes an external data clock of about 200 ns period on the link pin.
`timescale 1ns/1ps
module adc_serial_sequencer_sva #(
    parameter int CONV_CYC = 600
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic read_conv,
    input wire logic auto_scan_select,
    input wire logic clock_source_select,
    input wire logic serial_shift_clock_in,
    input wire logic chan_addr_bit0_out,
    input wire logic chan_addr_bit1_out,
    input wire logic chan_addr_oe,
    input wire logic core_sample,
    input wire logic busy_n,
    input wire logic frame_marker,
    input wire logic serial_result_oe
);
    // ========
    // Helper logic
    int         low_cnt;
    logic [1:0] addr_out;
    assign addr_out = {chan_addr_bit1_out, chan_addr_bit0_out};
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= busy_n ? 0 : low_cnt + 1;
        end
    end
    default clocking cb_main @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // ========
    // Properties
    conv_len_a: assert property ($rose(busy_n) |-> low_cnt >= CONV_CYC - 1)
        else $error("busy_n low shorter than the conversion");
    no_restart_a: assert property ((!busy_n) [*3] |-> !core_sample)
        else $error("conversion started while busy");
    scan_oe_a: assert property ($stable(auto_scan_select) [*5] |-> chan_addr_oe == auto_scan_select)
        else $error("address pin direction does not follow scan select");
    addr_inc_a: assert property ($changed(addr_out) && chan_addr_oe && $past(chan_addr_oe)
        |-> addr_out == $past(addr_out) + 2'h1 || addr_out == 2'h0) else $error("address out skipped");
    addr_busy_a: assert property ($changed(addr_out) && $past(chan_addr_oe) |-> busy_n)
        else $error("address out changed during conversion");
    sout_on_a: assert property ((clock_source_select && !cs_n && read_conv) [*5] |-> serial_result_oe)
        else $error("serial output not driven in read window");
    sout_off_a: assert property ((clock_source_select && (cs_n || !read_conv)) [*5] |-> !serial_result_oe)
        else $error("serial output driven outside read window");
    frame_len_a: assert property ($rose(frame_marker) |-> frame_marker [*7] ##[1:3] !frame_marker)
        else $error("frame marker not one data clock long");
    frame_cause_a: assert property ($rose(frame_marker)
        |-> $past(serial_shift_clock_in, 2) || $past(serial_shift_clock_in, 3)) else $error("frame marker w/o clock");
endmodule : adc_serial_sequencer_sva

bind adc_serial_sequencer adc_serial_sequencer_sva #(.CONV_CYC(CONV_CYC)) u_adc_serial_sequencer_sva (
    .mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .read_conv(read_conv),
    .auto_scan_select(auto_scan_select), .clock_source_select(clock_source_select),
    .serial_shift_clock_in(serial_shift_clock_in), .chan_addr_bit0_out(chan_addr_bit0_out),
    .chan_addr_bit1_out(chan_addr_bit1_out), .chan_addr_oe(chan_addr_oe), .core_sample(core_sample),
    .busy_n(busy_n), .frame_marker(frame_marker), .serial_result_oe(serial_result_oe));

// ---- host_link_model.sv ----
// Host side of the serial link: clocks frames out and feeds the chain input.
// Assumes the bench asks for a frame only while no conversion runs.
`timescale 1ns/1ps
module host_link_model (
    output logic        serial_shift_clock_in,
    output logic        chain_in,
    input  wire logic   result_in,
    input  wire logic   result_oe,
    output logic [15:0] got
);
    // ========
    // Link clock rests low between frames
    initial begin
        serial_shift_clock_in = 1'h0;
        chain_in = 1'h0;
        got = 16'h0;
    end
    // Called only between conversions
    task automatic frame(input int n, input logic [15:0] pat);
        #3;
        for (int j = 0; j < n; j++) begin
            chain_in = pat[j];
            #100 serial_shift_clock_in = 1'h1;
            #100;
            // A released line reads as wrong data, never as a lucky match
            got[j] = result_oe ? result_in : ~result_in;
            serial_shift_clock_in = 1'h0;
        end
        chain_in = ~chain_in;
    endtask : frame
endmodule : host_link_model

// ---- adc_serial_sequencer_tb.sv ----
// Self-checking bench for the converter sequencer with a host link model.
// Assumes a 40 MHz mclk and a shortened conversion count.
`timescale 1ns/1ps
module adc_serial_sequencer_tb;
    import adc_seq_pkg::*;
    localparam int CONV = 20;
    localparam int LIMIT = 4000;
    typedef struct packed {
        logic [1:0]  addr;
        logic [11:0] res;
        logic [1:0]  chan;
        logic [2:0]  chain;
    } row_t;
    logic        mclk, reset_n, cs_n, read_conv, analog_powerdown, auto_scan_select, sclk_in, chain_in;
    logic        sclk_out, sclk_oe, addr0_out, addr1_out, chan_addr_oe, core_sample, busy_n;
    logic        frame_marker, serial_result_out, serial_result_oe, result_invalid, result_overflow;
    logic [1:0]  addr_drv, core_channel, exp_ch;
    logic [11:0] core_result, rev;
    logic [15:0] host_got;
    int          n_fail, cmp_count, cycles;
    row_t        rows [4];

    adc_serial_sequencer #(.CONV_CYC(CONV)) u_adc_serial_sequencer (
        .mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .read_conv(read_conv),
        .analog_powerdown(analog_powerdown), .auto_scan_select(auto_scan_select),
        .clock_source_select(1'h1), .serial_shift_clock_in(sclk_in),
        .serial_shift_clock_out(sclk_out), .serial_shift_clock_oe(sclk_oe), .chain_in(chain_in),
        .chan_addr_bit0_in(chan_addr_oe ? addr0_out : addr_drv[0]),
        .chan_addr_bit1_in(chan_addr_oe ? addr1_out : addr_drv[1]),
        .chan_addr_bit0_out(addr0_out), .chan_addr_bit1_out(addr1_out), .chan_addr_oe(chan_addr_oe),
        .core_result(core_result), .core_channel(core_channel), .core_sample(core_sample),
        .busy_n(busy_n), .frame_marker(frame_marker), .serial_result_out(serial_result_out),
        .serial_result_oe(serial_result_oe), .result_invalid(result_invalid),
        .result_overflow(result_overflow));

    host_link_model u_host_link_model (
        .serial_shift_clock_in(sclk_in), .chain_in(chain_in), .result_in(serial_result_out),
        .result_oe(serial_result_oe), .got(host_got));

    // ========
    // Tasks
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 200 && busy_n !== lvl; i++) begin
            @(posedge mclk);
            #1;
        end
        check("busy_n", {15'h0, lvl}, {15'h0, busy_n});
    endtask : wait_busy

    task automatic convert(input logic [1:0] a, input logic [11:0] r);
        @(posedge mclk);
        addr_drv <= a;
        core_result <= r;
        @(posedge mclk);
        read_conv <= 1'h0;
        repeat (4) @(posedge mclk);
        read_conv <= 1'h1;
        wait_busy(1'h0);
    endtask : convert

    task automatic scan_run(input int n);
        for (int k = 0; k < n; k++) begin
            wait_busy(1'h0);
            repeat (2) @(posedge mclk);
            #1 check("scan channel", {14'h0, exp_ch}, {14'h0, core_channel});
            wait_busy(1'h1);
            @(posedge mclk);
            #1 check("scan address", {14'h1, exp_ch + 2'h1}, {13'h0, chan_addr_oe, addr1_out, addr0_out});
            exp_ch = exp_ch + 2'h1;
        end
    endtask : scan_run

    task automatic give_verdict();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    // ========
    // Clock and hang guard
    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail++;
            give_verdict();
        end
    end

    // ========
    // Sequence
    initial begin
        {reset_n, cs_n, read_conv, analog_powerdown, auto_scan_select} = 5'h0c;
        {addr_drv, core_result, n_fail, cmp_count, cycles} = '0;
        rows = '{'{2'h1, 12'ha5c, 2'h0, 3'h5}, '{2'h3, 12'hfff, 2'h1, 3'h2},
                 '{2'h0, 12'h001, 2'h3, 3'h7}, '{2'h2, 12'h800, 2'h0, 3'h0}};
        repeat (2) @(posedge mclk);
        reset_n <= 1'h1;
        repeat (3) @(posedge mclk);
        #1 check("reset outputs", 16'h0010, {7'h0, sclk_oe, serial_result_out, result_invalid,
            result_overflow, busy_n, chan_addr_oe, frame_marker, serial_result_oe, core_sample});
        @(posedge mclk);
        cs_n <= 1'h0;
        for (int i = 0; i < 4; i++) begin
            convert(rows[i].addr, rows[i].res);
            repeat (2) @(posedge mclk);
            #1 check("manual channel", {14'h0, rows[i].chan}, {14'h0, core_channel});
            // Second start with another address lands mid-conversion and must leave no trace
            @(posedge mclk);
            addr_drv <= ~rows[i].addr;
            read_conv <= 1'h0;
            repeat (4) @(posedge mclk);
            read_conv <= 1'h1;
            wait_busy(1'h1);
            rev = {<<{rows[i].res}};
            @(posedge mclk);
            u_host_link_model.frame(16, {13'h0, rows[i].chain});
            check("serial frame", {1'h0, rows[i].chain, rev}, {1'h0, host_got[15:1]});
        end
        exp_ch = rows[3].addr + 2'h1;
        @(posedge mclk);
        auto_scan_select <= 1'h1;
        read_conv <= 1'h0;
        scan_run(5);
        read_conv <= 1'h1;
        repeat (8) @(posedge mclk);
        wait_busy(1'h1);
        @(posedge mclk);
        analog_powerdown <= 1'h1;
        repeat (12) @(posedge mclk);
        analog_powerdown <= 1'h0;
        repeat (4) @(posedge mclk);
        read_conv <= 1'h0;
        exp_ch = 2'h0;
        scan_run(2);
        give_verdict();
    end
endmodule : adc_serial_sequencer_tb
